/* hall_temp_consts.svh */
// register indices, slots, masks and reset values of the sensor config bank
// assumes: included by bare name; APB byte address is four times the index
`ifndef HALL_TEMP_CONSTS_SVH
`define HALL_TEMP_CONSTS_SVH

`define IDX_MAG_COMP_LO     10'h092
`define IDX_MAG_MULT        10'h093
`define IDX_SW_UI           10'h0A0
`define IDX_SW_PROX_THR     10'h0A1
`define IDX_SW_TOUCH_THR    10'h0A2
`define IDX_TEMP_UI         10'h0C0
`define IDX_TEMP_MULT       10'h0C1
`define IDX_CAL_C2          10'h0C2
`define IDX_CAL_C3          10'h0C3
`define IDX_CAL_C4          10'h0C4
`define IDX_LAYOUT          10'h0E0
`define IDX_STATUS          10'h0E1

`define SLOT_MAG_COMP_LO    4'h0
`define SLOT_MAG_MULT       4'h1
`define SLOT_SW_UI          4'h2
`define SLOT_SW_PROX_THR    4'h3
`define SLOT_SW_TOUCH_THR   4'h4
`define SLOT_TEMP_UI        4'h5
`define SLOT_TEMP_MULT      4'h6
`define SLOT_CAL_C2         4'h7
`define SLOT_CAL_C3         4'h8
`define SLOT_CAL_C4         4'h9
`define SLOT_LAYOUT         4'hA
`define SLOT_STATUS         4'hB
`define NUM_STORED          11

`define MASK_FULL           8'hFF
`define MASK_SW_UI          8'h77
`define MASK_TEMP_UI        8'h7F
`define MASK_TEMP_MULT      8'h3F
`define MASK_LAYOUT         8'h01

`define RST_ZERO            8'h00
`define RST_SW_PROX_THR     8'h19
`define RST_SW_TOUCH_THR    8'h19
`define RST_LAYOUT          8'h01

`define F_COMP_HI           7:6
`define F_COARSE            5:4
`define F_FINE              3:0
`define F_HYST_T            5:4
`define F_HYST_P            1:0
`define B_LIN               6
`define B_SWAP              2
`define B_RESEED_PROX       6
`define B_RESEED_EN         5
`define F_RESEED_THR        4:0
`define F_PACK_MUL          7:4
`define F_PACK_DIV          3:0
`define B_LAYOUT            0

`endif

/* hall_temp_pkg.sv */
// types shared by the sensor config bank and its calibration decoder
// assumes: nothing beyond the standard language
package hall_temp_pkg;
	typedef logic [7:0] byte_t;
	typedef enum logic [1:0] {
		HYST_OFF       = 2'h0,
		HYST_QUARTER   = 2'h1,
		HYST_EIGHTH    = 2'h2,
		HYST_SIXTEENTH = 2'h3
	} hyst_e;
	typedef struct packed {
		logic       hit;
		logic [3:0] slot;
	} dec_s;
endpackage

/* temp_cal_if.sv */
// carrier between the register bank and the calibration decoder
// assumes: both ends on the same clock
`timescale 1ns/1ns
interface temp_cal_if;
	logic       layout_full;
	logic [7:0] c2;
	logic [7:0] c3;
	logic [7:0] c4;
	logic [8:0] mul;
	logic [8:0] div;
	logic [7:0] off;
	modport regs (output layout_full, c2, c3, c4, input mul, div, off);
	modport dec  (input layout_full, c2, c3, c4, output mul, div, off);
endinterface

/* temp_cal_decode.sv */
// turns the raw calibration bytes into multiplier, divider and offset
// assumes: bytes come from flops of the same clock; one cycle of latency
`timescale 1ns/1ns
`include "hall_temp_consts.svh"
module temp_cal_decode
	import hall_temp_pkg::*;
(
	input  wire logic   i_ref_clk,
	input  wire logic   i_rst_n,
	temp_cal_if.dec     cal
);
	// legacy nibbles are widened to nine bits, so 0xF cannot wrap here
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			cal.mul <= 9'h001;
			cal.div <= 9'h001;
			cal.off <= `RST_ZERO;
		end
		else if (cal.layout_full)
		begin
			cal.mul <= {1'b0, cal.c2} + 9'h001;
			cal.div <= {1'b0, cal.c3} + 9'h001;
			cal.off <= cal.c4;
		end
		else
		begin
			cal.mul <= {5'h00, cal.c2[`F_PACK_MUL]} + 9'h001;
			cal.div <= {5'h00, cal.c2[`F_PACK_DIV]} + 9'h001;
			cal.off <= cal.c3;
		end
	end

	a_full_mul: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$past(cal.layout_full) |-> cal.mul == {1'b0, $past(cal.c2)} + 9'h001)
		else $error("full-byte multiplier not value plus one");
	a_full_div_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		$past(cal.layout_full) |-> (cal.div == {1'b0, $past(cal.c3)} + 9'h001)
		&& (cal.off == $past(cal.c4)))
		else $error("relocated divider or offset wrong");
	a_packed_nibbles: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!$past(cal.layout_full) |-> (cal.mul == {5'h00, $past(cal.c2[`F_PACK_MUL])} + 9'h001)
		&& (cal.div == {5'h00, $past(cal.c2[`F_PACK_DIV])} + 9'h001)
		&& (cal.off == $past(cal.c3)))
		else $error("packed multiplier, divider or offset wrong");
endmodule

/* hall_temp_ui_config_regs.sv */
// magnetic switch and temperature ui configuration bank on an apb slave
// assumes: apb master on i_ref_clk; i_field_dir comes from logic on the same clock
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`include "hall_temp_consts.svh"

// Notes on behaviour
// - compensation low byte holds bits 7..0 of the 10-bit magnetic value
// - multiplier byte bits 7..6 are compensation bits 9..8, joined with low byte
// - multiplier byte: coarse select in bits 5..4, fine select in bits 3..0
// - touch hysteresis bits 5..4: off, quarter, eighth, sixteenth of threshold
// - proximity hysteresis bits 1..0 use the same four-way encoding
// - switch settings bit 6 turns output linearisation on
// - switch settings bit 2 swaps the reported field direction
// - switch settings byte resets to zero, all options off
// - proximity threshold byte is used directly, resets to 25
// - touch threshold is four times the stored byte, up to 1020
// - temperature settings bit 6 permits reseed during proximity
// - temperature settings bit 5 enables automatic reseeding
// - temperature settings bits 4..0 are the reseed threshold
// - temperature multiplier byte: coarse 5..4, fine 3..0, rest unused, reset zero
// - relocated layout: full-byte multiplier and divider, offset one address up
// - packed layout: nibbles give multiplier and divider as value plus one
// - relocated multiplier applies as value plus one, range 1 to 256
module hall_temp_ui_config_regs
	import hall_temp_pkg::*;
(
	input  wire logic        i_ref_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [11:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_field_dir,
	output logic             o_field_dir,
	output logic      [9:0]  o_mag_comp,
	output logic      [1:0]  o_mag_coarse,
	output logic      [3:0]  o_mag_fine,
	output logic             o_lin_en,
	output logic      [1:0]  o_touch_hyst_mode,
	output logic      [1:0]  o_prox_hyst_mode,
	output logic      [7:0]  o_prox_thr,
	output logic      [9:0]  o_touch_thr,
	output logic      [9:0]  o_prox_hyst_amt,
	output logic      [9:0]  o_touch_hyst_amt,
	output logic             o_reseed_in_prox,
	output logic             o_reseed_en,
	output logic      [4:0]  o_reseed_thr,
	output logic      [1:0]  o_temp_coarse,
	output logic      [3:0]  o_temp_fine,
	output logic      [8:0]  o_cal_mul,
	output logic      [8:0]  o_cal_div,
	output logic      [7:0]  o_cal_off
);
	byte_t        regs_q [`NUM_STORED];
	logic  [31:0] prdata_q;
	logic         err_q;
	logic  [9:0]  prox_amt_q;
	logic  [9:0]  touch_amt_q;
	logic         dir_q;
	dec_s         dec;
	logic         setup;
	logic         wr_en;
	logic  [31:0] rdata;

	temp_cal_if cal ();

	// address to storage slot; index 0xC4 exists only in the relocated layout
	function automatic dec_s decode(input logic [11:0] a, input logic full);
		dec_s d;
		d.hit  = 1'b1;
		d.slot = `SLOT_MAG_COMP_LO;
		if (a[1:0] != 2'h0)
			d.hit = 1'b0;
		else
		begin
			case (a[11:2])
				`IDX_MAG_COMP_LO:  d.slot = `SLOT_MAG_COMP_LO;
				`IDX_MAG_MULT:     d.slot = `SLOT_MAG_MULT;
				`IDX_SW_UI:        d.slot = `SLOT_SW_UI;
				`IDX_SW_PROX_THR:  d.slot = `SLOT_SW_PROX_THR;
				`IDX_SW_TOUCH_THR: d.slot = `SLOT_SW_TOUCH_THR;
				`IDX_TEMP_UI:      d.slot = `SLOT_TEMP_UI;
				`IDX_TEMP_MULT:    d.slot = `SLOT_TEMP_MULT;
				`IDX_CAL_C2:       d.slot = `SLOT_CAL_C2;
				`IDX_CAL_C3:       d.slot = `SLOT_CAL_C3;
				`IDX_CAL_C4:
				begin
					d.slot = `SLOT_CAL_C4;
					d.hit  = full;
				end
				`IDX_LAYOUT:       d.slot = `SLOT_LAYOUT;
				`IDX_STATUS:       d.slot = `SLOT_STATUS;
				default:           d.hit  = 1'b0;
			endcase
		end
		return d;
	endfunction

	// writable bits of each slot; the rest stay zero
	function automatic byte_t wmask(input logic [3:0] slot);
		case (slot)
			`SLOT_SW_UI:     return `MASK_SW_UI;
			`SLOT_TEMP_UI:   return `MASK_TEMP_UI;
			`SLOT_TEMP_MULT: return `MASK_TEMP_MULT;
			`SLOT_LAYOUT:    return `MASK_LAYOUT;
			default:         return `MASK_FULL;
		endcase
	endfunction

	function automatic byte_t rst_val(input logic [3:0] slot);
		case (slot)
			`SLOT_SW_PROX_THR:  return `RST_SW_PROX_THR;
			`SLOT_SW_TOUCH_THR: return `RST_SW_TOUCH_THR;
			`SLOT_LAYOUT:       return `RST_LAYOUT;
			default:            return `RST_ZERO;
		endcase
	endfunction

	// shared by both hysteresis bands so they cannot drift apart
	function automatic logic [9:0] hyst_amount(input logic [9:0] thr, input hyst_e mode);
		unique case (mode)
			HYST_OFF:       return 10'h000;
			HYST_QUARTER:   return thr >> 2;
			HYST_EIGHTH:    return thr >> 3;
			HYST_SIXTEENTH: return thr >> 4;
		endcase
	endfunction

	assign dec   = decode(i_paddr, regs_q[`SLOT_LAYOUT][`B_LAYOUT]);
	assign setup = i_psel & ~i_penable;
	// only byte lane 0 carries data; other lanes alone leave the register as is
	assign wr_en = i_psel & i_penable & i_pwrite & dec.hit & i_pstrb[0];

	// zero wait states: every access phase completes at once
	assign o_pready  = i_psel & i_penable;
	assign o_pslverr = err_q & i_psel & i_penable;
	assign o_prdata  = prdata_q;

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			for (int i = 0; i < `NUM_STORED; i++)
				regs_q[i] <= rst_val(4'(i));
		end
		else if (wr_en && dec.slot != `SLOT_STATUS)
			regs_q[dec.slot] <= i_pwdata[7:0] & wmask(dec.slot);
	end

	always_comb
	begin
		rdata = 32'h0000_0000;
		if (dec.slot == `SLOT_STATUS)
			rdata = {7'h00, o_cal_mul, 6'h00, o_touch_thr};
		else
			rdata = {24'h00_0000, regs_q[dec.slot]};
	end

	// read data and error are caught in the setup phase and held for the access
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			prdata_q <= 32'h0000_0000;
			err_q    <= 1'b0;
		end
		else if (setup)
		begin
			prdata_q <= (dec.hit && !i_pwrite) ? rdata : 32'h0000_0000;
			err_q    <= ~dec.hit;
		end
	end

	assign o_mag_comp   = {regs_q[`SLOT_MAG_MULT][`F_COMP_HI], regs_q[`SLOT_MAG_COMP_LO]};
	assign o_mag_coarse = regs_q[`SLOT_MAG_MULT][`F_COARSE];
	assign o_mag_fine   = regs_q[`SLOT_MAG_MULT][`F_FINE];

	assign o_lin_en          = regs_q[`SLOT_SW_UI][`B_LIN];
	assign o_touch_hyst_mode = regs_q[`SLOT_SW_UI][`F_HYST_T];
	assign o_prox_hyst_mode  = regs_q[`SLOT_SW_UI][`F_HYST_P];
	assign o_prox_thr        = regs_q[`SLOT_SW_PROX_THR];
	assign o_touch_thr       = {regs_q[`SLOT_SW_TOUCH_THR], 2'h0};

	assign o_reseed_in_prox = regs_q[`SLOT_TEMP_UI][`B_RESEED_PROX];
	assign o_reseed_en      = regs_q[`SLOT_TEMP_UI][`B_RESEED_EN];
	assign o_reseed_thr     = regs_q[`SLOT_TEMP_UI][`F_RESEED_THR];
	assign o_temp_coarse    = regs_q[`SLOT_TEMP_MULT][`F_COARSE];
	assign o_temp_fine      = regs_q[`SLOT_TEMP_MULT][`F_FINE];

	// hysteresis band registered; trails a threshold write by one cycle
	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
		begin
			prox_amt_q  <= 10'h000;
			touch_amt_q <= 10'h000;
		end
		else
		begin
			prox_amt_q  <= hyst_amount({2'h0, o_prox_thr}, hyst_e'(o_prox_hyst_mode));
			touch_amt_q <= hyst_amount(o_touch_thr, hyst_e'(o_touch_hyst_mode));
		end
	end
	assign o_prox_hyst_amt  = prox_amt_q;
	assign o_touch_hyst_amt = touch_amt_q;

	always_ff @(posedge i_ref_clk)
	begin
		if (!i_rst_n)
			dir_q <= 1'b0;
		else
			dir_q <= i_field_dir ^ regs_q[`SLOT_SW_UI][`B_SWAP];
	end
	assign o_field_dir = dir_q;

	assign cal.layout_full = regs_q[`SLOT_LAYOUT][`B_LAYOUT];
	assign cal.c2          = regs_q[`SLOT_CAL_C2];
	assign cal.c3          = regs_q[`SLOT_CAL_C3];
	assign cal.c4          = regs_q[`SLOT_CAL_C4];
	assign o_cal_mul       = cal.mul;
	assign o_cal_div       = cal.div;
	assign o_cal_off       = cal.off;

	temp_cal_decode u_cal_decode (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.cal       (cal)
	);

	a_comp_low_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wr_en && dec.slot == `SLOT_MAG_COMP_LO) |=> o_mag_comp[7:0] == $past(i_pwdata[7:0]))
		else $error("compensation low byte not stored");
	a_comp_high_join: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wr_en && dec.slot == `SLOT_MAG_MULT) |=> o_mag_comp[9:8] == $past(i_pwdata[7:6]))
		else $error("compensation upper bits not joined");
	a_mult_fields: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wr_en && dec.slot == `SLOT_MAG_MULT)
		|=> (o_mag_coarse == $past(i_pwdata[5:4])) && (o_mag_fine == $past(i_pwdata[3:0])))
		else $error("magnetic coarse or fine selection wrong");
	a_touch_hyst_16: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(o_touch_hyst_mode == 2'h3) |=> o_touch_hyst_amt == ($past(o_touch_thr) >> 4))
		else $error("touch hysteresis sixteenth wrong");
	a_prox_hyst_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(o_prox_hyst_mode == 2'h0) |=> o_prox_hyst_amt == 10'h000)
		else $error("proximity hysteresis not disabled");
	a_lin_follows: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wr_en && dec.slot == `SLOT_SW_UI) |=> o_lin_en == $past(i_pwdata[6]))
		else $error("linearisation enable not taken");
	a_dir_swap: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		i_rst_n |=> o_field_dir
		== ($past(i_field_dir) ^ $past(regs_q[`SLOT_SW_UI][`B_SWAP])))
		else $error("field direction swap wrong");
	a_reset_values: assert property (@(posedge i_ref_clk)
		!i_rst_n |=> (regs_q[`SLOT_SW_UI] == 8'h00) && (o_prox_thr == 8'h19))
		else $error("switch settings or proximity threshold reset value wrong");
	a_touch_times_4: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wr_en && dec.slot == `SLOT_SW_TOUCH_THR)
		|=> o_touch_thr == {$past(i_pwdata[7:0]), 2'h0})
		else $error("touch threshold not four times byte");
	a_reseed_fields: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wr_en && dec.slot == `SLOT_TEMP_UI)
		|=> (o_reseed_en == $past(i_pwdata[5])) && (o_reseed_in_prox == $past(i_pwdata[6]))
		&& (o_reseed_thr == $past(i_pwdata[4:0])))
		else $error("temperature reseed controls wrong");
	a_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(regs_q[`SLOT_SW_UI][7] == 1'b0) && (regs_q[`SLOT_SW_UI][3] == 1'b0)
		&& (regs_q[`SLOT_TEMP_UI][7] == 1'b0) && (regs_q[`SLOT_TEMP_MULT][7:6] == 2'h0))
		else $error("reserved bit set");
	a_unmapped_err: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(setup && !dec.hit) |=> (i_psel && i_penable) |-> o_pslverr)
		else $error("unmapped access not flagged");

	// bus side: refusals answer in the access phase and carry zero data
	a_c4_packed_err: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(setup && i_paddr == {`IDX_CAL_C4, 2'h0} && !cal.layout_full)
		|=> (i_psel && i_penable) |-> o_pslverr)
		else $error("offset slot not refused in packed layout");
	a_c4_full_ok: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(setup && i_paddr == {`IDX_CAL_C4, 2'h0} && cal.layout_full)
		|=> (i_psel && i_penable) |-> !o_pslverr)
		else $error("offset slot refused in relocated layout");
	a_err_rdata_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_psel && i_penable && o_pslverr) |-> o_prdata == 32'h0000_0000)
		else $error("refused access returned data");
	a_write_rdata_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(setup && i_pwrite) |=> o_prdata == 32'h0000_0000)
		else $error("write returned data");
	a_idle_no_ready: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		!i_psel |-> !o_pready && !o_pslverr)
		else $error("ready or error outside a transfer");
	a_strobe_gate: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(i_psel && i_penable && i_pwrite && !i_pstrb[0])
		|=> $stable(o_mag_comp) && $stable(o_prox_thr) && $stable(o_touch_thr)
		&& $stable(o_reseed_thr))
		else $error("write without lane 0 strobe changed a field");

	// thresholds and bands; a band follows its mode one cycle later
	a_prox_thr_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wr_en && dec.slot == `SLOT_SW_PROX_THR) |=> o_prox_thr == $past(i_pwdata[7:0]))
		else $error("proximity threshold not stored");
	a_touch_reset: assert property (@(posedge i_ref_clk)
		!i_rst_n |=> o_touch_thr == {`RST_SW_TOUCH_THR, 2'h0})
		else $error("touch threshold reset value wrong");
	a_touch_hyst_off: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(o_touch_hyst_mode == HYST_OFF) |=> o_touch_hyst_amt == 10'h000)
		else $error("touch hysteresis not disabled");
	a_touch_hyst_4: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(o_touch_hyst_mode == HYST_QUARTER)
		|=> o_touch_hyst_amt == ($past(o_touch_thr) >> 2))
		else $error("touch hysteresis quarter wrong");
	a_touch_hyst_8: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(o_touch_hyst_mode == HYST_EIGHTH)
		|=> o_touch_hyst_amt == ($past(o_touch_thr) >> 3))
		else $error("touch hysteresis eighth wrong");
	a_prox_hyst_4: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(o_prox_hyst_mode == HYST_QUARTER)
		|=> o_prox_hyst_amt == ({2'h0, $past(o_prox_thr)} >> 2))
		else $error("proximity hysteresis quarter wrong");
	a_prox_hyst_8: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(o_prox_hyst_mode == HYST_EIGHTH)
		|=> o_prox_hyst_amt == ({2'h0, $past(o_prox_thr)} >> 3))
		else $error("proximity hysteresis eighth wrong");
	a_prox_hyst_16: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(o_prox_hyst_mode == HYST_SIXTEENTH)
		|=> o_prox_hyst_amt == ({2'h0, $past(o_prox_thr)} >> 4))
		else $error("proximity hysteresis sixteenth wrong");

	// temperature fields and reset-time state
	a_reseed_in_prox: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wr_en && dec.slot == `SLOT_TEMP_UI)
		|=> o_reseed_in_prox == $past(i_pwdata[`B_RESEED_PROX]))
		else $error("reseed in proximity not taken");
	a_reseed_thr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wr_en && dec.slot == `SLOT_TEMP_UI)
		|=> o_reseed_thr == $past(i_pwdata[`F_RESEED_THR]))
		else $error("reseed threshold not taken");
	a_temp_mult_fields: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
		(wr_en && dec.slot == `SLOT_TEMP_MULT)
		|=> (o_temp_coarse == $past(i_pwdata[5:4])) && (o_temp_fine == $past(i_pwdata[3:0])))
		else $error("temperature coarse or fine selection wrong");
	a_temp_mult_reset: assert property (@(posedge i_ref_clk)
		!i_rst_n |=> regs_q[`SLOT_TEMP_MULT] == `RST_ZERO)
		else $error("temperature multiplier reset value wrong");
	a_lin_reset: assert property (@(posedge i_ref_clk)
		!i_rst_n |=> !o_lin_en && !regs_q[`SLOT_SW_UI][`B_SWAP]
		&& (o_touch_hyst_mode == HYST_OFF) && (o_prox_hyst_mode == HYST_OFF))
		else $error("switch options not off after reset");
	a_hyst_reset: assert property (@(posedge i_ref_clk)
		!i_rst_n |=> (o_prox_hyst_amt == 10'h000) && (o_touch_hyst_amt == 10'h000))
		else $error("hysteresis bands not zero after reset");
endmodule

/* hall_temp_ui_config_regs_test.sv */
// self-checking bench for the magnetic switch and temperature ui config bank
// assumes: apb slave with zero wait states; byte address is four times the index
`timescale 1ns/1ns
module hall_temp_ui_config_regs_test;
	import hall_temp_pkg::*;

	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0]  pstrb;
	logic        field_dir;
	logic [31:0] o_prdata;
	logic        o_pready;
	logic        o_pslverr;
	logic        o_field_dir;
	logic [9:0]  o_mag_comp;
	logic [1:0]  o_mag_coarse;
	logic [3:0]  o_mag_fine;
	logic        o_lin_en;
	logic [1:0]  o_touch_hyst_mode;
	logic [1:0]  o_prox_hyst_mode;
	logic [7:0]  o_prox_thr;
	logic [9:0]  o_touch_thr;
	logic [9:0]  o_prox_hyst_amt;
	logic [9:0]  o_touch_hyst_amt;
	logic        o_reseed_in_prox;
	logic        o_reseed_en;
	logic [4:0]  o_reseed_thr;
	logic [1:0]  o_temp_coarse;
	logic [3:0]  o_temp_fine;
	logic [8:0]  o_cal_mul;
	logic [8:0]  o_cal_div;
	logic [7:0]  o_cal_off;
	logic [31:0] rdat;
	logic        rerr;
	int          n_errors;
	int          checked;

	hall_temp_ui_config_regs u_hall_temp_ui_config_regs (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
		.i_field_dir(field_dir), .o_field_dir(o_field_dir), .o_mag_comp(o_mag_comp),
		.o_mag_coarse(o_mag_coarse), .o_mag_fine(o_mag_fine), .o_lin_en(o_lin_en),
		.o_touch_hyst_mode(o_touch_hyst_mode), .o_prox_hyst_mode(o_prox_hyst_mode),
		.o_prox_thr(o_prox_thr), .o_touch_thr(o_touch_thr),
		.o_prox_hyst_amt(o_prox_hyst_amt), .o_touch_hyst_amt(o_touch_hyst_amt),
		.o_reseed_in_prox(o_reseed_in_prox), .o_reseed_en(o_reseed_en),
		.o_reseed_thr(o_reseed_thr), .o_temp_coarse(o_temp_coarse),
		.o_temp_fine(o_temp_fine), .o_cal_mul(o_cal_mul), .o_cal_div(o_cal_div),
		.o_cal_off(o_cal_off)
	);

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// idle edge first, so a release and the next setup never share a time step
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r, output logic e);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= s;
		@(posedge clk);
		penable <= 1'b1;
		// no assumed latency; only the watchdog ends a hung wait
		do
		begin
			@(posedge clk);
		end
		while (o_pready !== 1'b1);
		r = o_prdata;
		e = o_pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		xfer(1'b1, a, {24'h000000, d}, 4'hF, rdat, rerr);
		chk(32'(rerr), 32'h0);
	endtask

	task automatic rd(input logic [11:0] a, input logic [7:0] exp);
		xfer(1'b0, a, 32'h0, 4'hF, rdat, rerr);
		chk(rdat, {24'h000000, exp});
		chk(32'(rerr), 32'h0);
	endtask

	// hysteresis and calibration outputs lag the register by one more cycle
	task automatic settle();
		repeat (4) @(posedge clk);
	endtask

	function automatic logic [31:0] hamt(input logic [9:0] t, input int m);
		return (m == 0) ? 32'h0 : 32'(t >> (m + 1));
	endfunction

	initial
	begin
		#1000000;
		n_errors++;
		$display("CHECK FAILED at %0t: watchdog expired", $time);
		tally_and_finish();
	end

	initial
	begin
		n_errors = 0;
		checked = 0;
		rst_n <= 1'b0;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 12'h000;
		pwdata <= 32'h0;
		pstrb <= 4'hF;
		field_dir <= 1'b1;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		// reset values
		rd(12'h280, 8'h00);
		rd(12'h284, 8'h19);
		rd(12'h288, 8'h19);
		rd(12'h300, 8'h00);
		rd(12'h304, 8'h00);
		rd(12'h308, 8'h00);
		rd(12'h310, 8'h00);
		rd(12'h380, 8'h01);
		chk(32'(o_touch_thr), 32'h64);
		chk(32'(o_cal_mul), 32'h1);
		chk(32'(o_touch_hyst_amt), 32'h0);
		chk(32'(o_field_dir), 32'h1);
		// compensation split over two bytes
		wr(12'h248, 8'hA5);
		wr(12'h24C, 8'hD7);
		rd(12'h248, 8'hA5);
		rd(12'h24C, 8'hD7);
		settle();
		chk(32'(o_mag_comp), 32'h3A5);
		chk(32'(o_mag_coarse), 32'h1);
		chk(32'(o_mag_fine), 32'h7);
		// reserved bits drop, swap and linearisation on
		wr(12'h280, 8'hFF);
		rd(12'h280, 8'h77);
		settle();
		chk(32'(o_lin_en), 32'h1);
		chk(32'(o_field_dir), 32'h0);
		wr(12'h280, 8'h00);
		settle();
		chk(32'(o_lin_en), 32'h0);
		chk(32'(o_field_dir), 32'h1);
		// every hysteresis mode, touch threshold at its top
		wr(12'h284, 8'hF0);
		wr(12'h288, 8'hFF);
		for (int m = 0; m < 4; m++)
		begin
			wr(12'h280, 8'((m << 4) | m));
			settle();
			chk(32'(o_touch_hyst_mode), 32'(m));
			chk(32'(o_prox_hyst_mode), 32'(m));
			chk(32'(o_touch_hyst_amt), hamt(10'h3FC, m));
			chk(32'(o_prox_hyst_amt), hamt(10'h0F0, m));
		end
		chk(32'(o_touch_thr), 32'h3FC);
		chk(32'(o_prox_thr), 32'hF0);
		// write with no byte strobe is dropped
		xfer(1'b1, 12'h284, 32'h0, 4'h0, rdat, rerr);
		chk(32'(rerr), 32'h0);
		rd(12'h284, 8'hF0);
		// temperature settings
		wr(12'h300, 8'hFF);
		rd(12'h300, 8'h7F);
		wr(12'h300, 8'h25);
		settle();
		chk(32'(o_reseed_in_prox), 32'h0);
		chk(32'(o_reseed_en), 32'h1);
		chk(32'(o_reseed_thr), 32'h05);
		wr(12'h300, 8'h4A);
		settle();
		chk(32'(o_reseed_in_prox), 32'h1);
		chk(32'(o_reseed_en), 32'h0);
		chk(32'(o_reseed_thr), 32'h0A);
		wr(12'h304, 8'hD6);
		rd(12'h304, 8'h16);
		settle();
		chk(32'(o_temp_coarse), 32'h1);
		chk(32'(o_temp_fine), 32'h6);
		// relocated layout, multiplier one below its largest value
		wr(12'h308, 8'hFE);
		wr(12'h30C, 8'h00);
		wr(12'h310, 8'hAB);
		settle();
		chk(32'(o_cal_mul), 32'h0FF);
		chk(32'(o_cal_div), 32'h001);
		chk(32'(o_cal_off), 32'hAB);
		// packed layout, nibbles kept below all-ones
		wr(12'h380, 8'h00);
		wr(12'h308, 8'hE3);
		wr(12'h30C, 8'h5C);
		settle();
		chk(32'(o_cal_mul), 32'h00F);
		chk(32'(o_cal_div), 32'h004);
		chk(32'(o_cal_off), 32'h5C);
		// status is read-only: a write is dropped without error
		wr(12'h384, 8'h55);
		xfer(1'b0, 12'h384, 32'h0, 4'hF, rdat, rerr);
		chk(32'(rerr), 32'h0);
		chk(rdat, 32'h000F_03FC);
		xfer(1'b0, 12'h310, 32'h0, 4'hF, rdat, rerr);
		chk(32'(rerr), 32'h1);
		// unmapped and misaligned accesses are refused
		xfer(1'b0, 12'h3FC, 32'h0, 4'hF, rdat, rerr);
		chk(32'(rerr), 32'h1);
		chk(rdat, 32'h0);
		xfer(1'b1, 12'h285, 32'h11, 4'hF, rdat, rerr);
		chk(32'(rerr), 32'h1);
		rd(12'h284, 8'hF0);
		tally_and_finish();
	end
endmodule
